// ===== design/dout_channel.sv
// Top of the digital output pulse channel with registers, sequencer and line drive.
module dout_channel
    import dout_pkg::*;
#(
    parameter int unsigned TICK_PERIOD = TICK_CYCLES
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        failsafe_i,
    output logic             drive_hi_o,
    output logic             drive_lo_o,
    output logic             line_oe_o,
    output logic             active_o
);
    // ========================================================================
    // Submodules.
    tick_if ti ();

    tick_gen #(.PERIOD(TICK_PERIOD)) u_tick (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .t       (ti.src)
    );

    interval_cnt u_cnt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .t       (ti.cnt)
    );

    // ========================================================================
    // Failsafe input synchroniser and edge detect.
    logic fs_s1_q;
    logic fs_s2_q;
    logic fs_s3_q;
    logic fs_evt;

    // Two flops bring the pin in; the third gives the edge.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fs_s1_q <= 1'b0;
            fs_s2_q <= 1'b0;
            fs_s3_q <= 1'b0;
        end else begin
            fs_s1_q <= failsafe_i;
            fs_s2_q <= fs_s1_q;
            fs_s3_q <= fs_s2_q;
        end
    end

    assign fs_evt = fs_s2_q && !fs_s3_q;

    // ========================================================================
    // Registers.
    logic [7:0]         ctrl_q;
    logic [7:0]         ctrl_d;
    logic [15:0]        count_q;
    logic [15:0]        count_d;
    logic [WIDTH_W-1:0] inact_q;
    logic [WIDTH_W-1:0] inact_d;
    logic [WIDTH_W-1:0] act_q;
    logic [WIDTH_W-1:0] act_d;
    logic [WIDTH_W-1:0] dly_q;
    logic [WIDTH_W-1:0] dly_d;
    logic [15:0]        rdata_d;
    logic               cmd_act;
    logic               cmd_deact;
    logic [WIDTH_W-1:0] wr_width;

    // Clamps a written width to the legal range.
    always_comb begin
        wr_width = wdata_i[WIDTH_W-1:0];
        if (wr_width < WIDTH_MIN) begin
            wr_width = WIDTH_MIN;
        end else if (wr_width > WIDTH_MAX) begin
            wr_width = WIDTH_MAX;
        end
    end

    // Command strobes from writes to the command register.
    assign cmd_act   = wr_i && (addr_i == OFS_CMD) && wdata_i[CMD_ACT_BIT];
    assign cmd_deact = wr_i && (addr_i == OFS_CMD) && wdata_i[CMD_DEACT_BIT];

    // ========================================================================
    // Sequencer state.
    typedef enum logic [2:0] {S_IDLE, S_ACT, S_INACT, S_RISE_WAIT, S_FALL_WAIT, S_DEACT_WAIT}
        seq_t;
    seq_t        st_q;
    seq_t        st_d;
    logic        out_q;
    logic        out_d;
    logic [15:0] left_q;
    logic [15:0] left_d;
    logic        load;
    logic [13:0] ld_w;
    beh_t        beh;
    fs_t         fs_act;

    assign beh    = beh_t'(ctrl_q[CTRL_BEH_LSB +: 2]);
    assign fs_act = fs_t'(ctrl_q[CTRL_FS_LSB +: 2]);

    // Register writes and read data.
    always_comb begin
        ctrl_d  = ctrl_q;
        count_d = count_q;
        inact_d = inact_q;
        act_d   = act_q;
        dly_d   = dly_q;
        if (wr_i) begin
            case (addr_i)
                OFS_CTRL:    ctrl_d  = wdata_i[7:0];
                OFS_COUNT:   count_d = (wdata_i == 16'h0000) ? COUNT_RST : wdata_i;
                OFS_INACT_W: inact_d = wr_width;
                OFS_ACT_W:   act_d   = wr_width;
                OFS_DELAY:   dly_d   = wr_width;
                default:     ctrl_d  = ctrl_q;
            endcase
        end
        rdata_d = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                OFS_CTRL:    rdata_d = {8'h00, ctrl_q};
                OFS_COUNT:   rdata_d = count_q;
                OFS_INACT_W: rdata_d = {2'b00, inact_q};
                OFS_ACT_W:   rdata_d = {2'b00, act_q};
                OFS_DELAY:   rdata_d = {2'b00, dly_q};
                OFS_STATUS:  rdata_d = {10'h000, left_q[2:0] == 3'h0, 1'b0,
                                        (st_q != S_IDLE), 2'b00, out_q};
                default:     rdata_d = 16'h0000;
            endcase
        end
    end

    // Sequencer: commands, timed phases and failsafe.
    always_comb begin
        st_d   = st_q;
        out_d  = out_q;
        left_d = left_q;
        load   = 1'b0;
        ld_w   = act_q;
        if (cmd_deact) begin
            case (beh)
                BEH_MANUAL: begin
                    st_d  = S_IDLE;
                    out_d = 1'b0;
                end
                BEH_PULSE: begin
                    st_d  = S_IDLE;
                    out_d = 1'b0;
                end
                default: begin
                    st_d = S_DEACT_WAIT;
                    load = 1'b1;
                    ld_w = dly_q;
                end
            endcase
        end else if (cmd_act) begin
            case (beh)
                BEH_MANUAL: begin
                    st_d  = S_IDLE;
                    out_d = 1'b1;
                end
                BEH_PULSE: begin
                    st_d   = S_ACT;
                    out_d  = 1'b1;
                    left_d = count_q;
                    load   = 1'b1;
                    ld_w   = act_q;
                end
                BEH_RISE_DLY: begin
                    st_d  = S_RISE_WAIT;
                    out_d = 1'b0;
                    load  = 1'b1;
                    ld_w  = dly_q;
                end
                default: begin
                    st_d  = S_FALL_WAIT;
                    out_d = 1'b1;
                    load  = 1'b1;
                    ld_w  = dly_q;
                end
            endcase
        end else if (ti.done) begin
            case (st_q)
                S_ACT: begin
                    st_d  = S_INACT;
                    out_d = 1'b0;
                    load  = 1'b1;
                    ld_w  = inact_q;
                end
                S_INACT: begin
                    if (ctrl_q[CTRL_CNT_BIT] && left_q <= 16'h0001) begin
                        st_d   = S_IDLE;
                        left_d = 16'h0000;
                    end else begin
                        st_d   = S_ACT;
                        out_d  = 1'b1;
                        load   = 1'b1;
                        ld_w   = act_q;
                        left_d = ctrl_q[CTRL_CNT_BIT] ? left_q - 1'b1 : left_q;
                    end
                end
                S_RISE_WAIT: begin
                    st_d  = S_IDLE;
                    out_d = 1'b1;
                end
                S_FALL_WAIT, S_DEACT_WAIT: begin
                    st_d  = S_IDLE;
                    out_d = 1'b0;
                end
                default: st_d = S_IDLE;
            endcase
        end
        // Failsafe overrides the running sequence when it forces a level.
        if (fs_evt && !cmd_act && !cmd_deact) begin
            case (fs_act)
                FS_ACTIVE: begin
                    st_d  = S_IDLE;
                    out_d = 1'b1;
                end
                FS_INACTIVE: begin
                    st_d  = S_IDLE;
                    out_d = 1'b0;
                end
                default: out_d = out_d;
            endcase
        end
    end

    assign ti.load  = load;
    assign ti.width = ld_w;

    // ========================================================================
    // Line drive from direction, style and output state.
    logic   hi_d;
    logic   lo_d;
    logic   oe_d;
    style_t style;

    // Style follows the new control word, as the direction bit does.
    assign style = style_t'(ctrl_d[CTRL_STYLE_LSB +: 2]);

    // Decodes the drive pins for the next output state.
    always_comb begin
        oe_d = 1'b0;
        hi_d = 1'b0;
        lo_d = 1'b0;
        if (ctrl_d[CTRL_DIR_BIT]) begin
            case (style)
                STYLE_VOLT: begin
                    hi_d = out_d;
                    oe_d = out_d;
                end
                STYLE_BOTH: begin
                    hi_d = out_d;
                    lo_d = !out_d;
                    oe_d = 1'b1;
                end
                default: begin
                    lo_d = out_d;
                    oe_d = out_d;
                end
            endcase
        end
    end

    // Registers all state and outputs.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q     <= CTRL_RST;
            count_q    <= COUNT_RST;
            inact_q    <= WIDTH_RST;
            act_q      <= WIDTH_RST;
            dly_q      <= WIDTH_RST;
            rdata_o    <= 16'h0000;
            st_q       <= S_IDLE;
            out_q      <= 1'b0;
            left_q     <= 16'h0000;
            drive_hi_o <= 1'b0;
            drive_lo_o <= 1'b0;
            line_oe_o  <= 1'b0;
            active_o   <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            count_q    <= count_d;
            inact_q    <= inact_d;
            act_q      <= act_d;
            dly_q      <= dly_d;
            rdata_o    <= rdata_d;
            st_q       <= st_d;
            out_q      <= out_d;
            left_q     <= left_d;
            drive_hi_o <= hi_d;
            drive_lo_o <= lo_d;
            line_oe_o  <= oe_d;
            active_o   <= out_d;
        end
    end
endmodule : dout_channel

// ===== shared/dout_pkg.sv
// Package with constants, types and register map of the digital output pulse channel.
// ============================================================================
// How it works
// - Drive line only when output direction selected.
// - Ground-drive style grounds line while active.
// - Voltage-drive style supplies voltage while active.
// - Combined style grounds inactive, supplies voltage active.
// - Manual behaviour follows only activate/deactivate commands and the failsafe action.
// - Pulse behaviour alternates phases after activate.
// - Rise delay: inactive for delay, then active.
// - Fall delay: active, inactive after delay.
// - Continuous pulse style repeats without limit.
// - Counted style emits configured sequences then stops.
// - Inactive width one to 9999 ticks.
// - Active width one to 9999 ticks.
// - Delay interval one to 9999 ticks.
// - Rising edge on failsafe input applies failsafe action.
// - Failsafe: unchanged, force active, force inactive.
package dout_pkg;

    // ========================================================================
    // Timing.
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned TICK_MS      = 100;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned PRESC_W      = 20;
    localparam int unsigned WIDTH_W      = 14;
    localparam logic [13:0] WIDTH_MIN    = 14'h0001;
    localparam logic [13:0] WIDTH_MAX    = 14'h270F;

    // ========================================================================
    // Register offsets.
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_CMD      = 4'h1;
    localparam logic [3:0] OFS_COUNT    = 4'h2;
    localparam logic [3:0] OFS_INACT_W  = 4'h3;
    localparam logic [3:0] OFS_ACT_W    = 4'h4;
    localparam logic [3:0] OFS_DELAY    = 4'h5;
    localparam logic [3:0] OFS_STATUS   = 4'h6;

    // ========================================================================
    // Control register field positions.
    localparam int unsigned CTRL_DIR_BIT   = 0;
    localparam int unsigned CTRL_STYLE_LSB = 1;
    localparam int unsigned CTRL_BEH_LSB   = 3;
    localparam int unsigned CTRL_CNT_BIT   = 5;
    localparam int unsigned CTRL_FS_LSB    = 6;
    localparam int unsigned CMD_ACT_BIT    = 0;
    localparam int unsigned CMD_DEACT_BIT  = 1;

    // ========================================================================
    // Reset values.
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] COUNT_RST  = 16'h0001;
    localparam logic [13:0] WIDTH_RST  = 14'h0001;

    // ========================================================================
    // Encodings.
    typedef enum logic [1:0] {STYLE_GND = 2'h0, STYLE_VOLT = 2'h1, STYLE_BOTH = 2'h2}
        style_t;
    typedef enum logic [1:0] {BEH_MANUAL = 2'h0, BEH_PULSE = 2'h1, BEH_RISE_DLY = 2'h2,
        BEH_FALL_DLY = 2'h3} beh_t;
    typedef enum logic [1:0] {FS_NONE = 2'h0, FS_ACTIVE = 2'h1, FS_INACTIVE = 2'h2}
        fs_t;

endpackage : dout_pkg

// ===== shared/tick_if.sv
// Interface carrying the interval tick and the interval counter handshake.
interface tick_if;
    logic        tick;
    logic        load;
    logic [13:0] width;
    logic        done;

    modport src (input load, output tick);
    modport use_tick (input tick);
    modport ctl (output load, output width, input done);
    modport cnt (input load, input width, input tick, output done);
endinterface : tick_if

// ===== design/tick_gen.sv
// Prescaler producing one-cycle 100 ms tick.
module tick_gen
    import dout_pkg::*;
#(
    parameter int unsigned PERIOD = TICK_CYCLES
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    tick_if.src       t
);
    logic [PRESC_W-1:0] cnt_q;
    logic [PRESC_W-1:0] cnt_d;
    logic               tick_q;
    logic               tick_d;

    // Counts clock cycles and wraps once per tick period; a load restarts the count so
    // every phase lasts whole ticks and no stale tick cuts its first one short.
    always_comb begin
        tick_d = !t.load && (cnt_q == PRESC_W'(PERIOD - 1));
        cnt_d  = (tick_d || t.load) ? '0 : cnt_q + 1'b1;
    end

    // Registers the prescaler.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign t.tick = tick_q;
endmodule : tick_gen

// ===== design/interval_cnt.sv
// Down counter timing one phase or delay in ticks.
module interval_cnt
    import dout_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    tick_if.cnt       t
);
    logic [WIDTH_W-1:0] rem_q;
    logic [WIDTH_W-1:0] rem_d;
    logic               run_q;
    logic               run_d;
    logic               done_q;
    logic               done_d;

    // Loads the width and counts down only on ticks; done is a one-cycle pulse.
    always_comb begin
        rem_d  = rem_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (t.load) begin
            rem_d = t.width;
            run_d = 1'b1;
        end else if (run_q && t.tick) begin
            if (rem_q <= WIDTH_MIN) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                rem_d = rem_q - 1'b1;
            end
        end
    end

    // Registers the counter.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rem_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            rem_q  <= rem_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end

    assign t.done = done_q;
endmodule : interval_cnt

// ===== tb/dout_channel_monitor.sv
// Checker that watches the ports of the digital output pulse channel.
module dout_channel_monitor
    import dout_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        failsafe_i,
    input wire logic        drive_hi_o,
    input wire logic        drive_lo_o,
    input wire logic        line_oe_o,
    input wire logic        active_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================================================
    // Shadow of the control register and command decode.
    logic [7:0] ctrl_d;
    logic [7:0] ctrl_q;
    logic       cmd_act;
    logic       cmd_deact;
    logic [1:0] style;
    logic [1:0] beh;
    logic [1:0] fs;

    // Follows every control write so the checks know the current setup.
    always_comb begin
        ctrl_d = (wr_i && addr_i == OFS_CTRL) ? wdata_i[7:0] : ctrl_q;
    end

    // Registers the shadow copy.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Deactivate wins over activate when both bits are written.
    assign cmd_act   = wr_i && addr_i == OFS_CMD && wdata_i[0] && !wdata_i[1];
    assign cmd_deact = wr_i && addr_i == OFS_CMD && wdata_i[1];
    assign style     = ctrl_q[2:1];
    assign beh       = ctrl_q[4:3];
    assign fs        = ctrl_q[7:6];

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside read answer");
    a_line_needs_dir: assert property (line_oe_o |-> ctrl_q[0])
        else $error("line driven while direction is input");
    a_volt_when_active: assert property (drive_hi_o |-> active_o && line_oe_o)
        else $error("voltage driven while output inactive");
    a_ground_style: assert property (ctrl_q[0] && style == STYLE_GND && active_o
        |-> drive_lo_o && !drive_hi_o) else $error("ground style drive wrong");
    a_voltage_style: assert property (ctrl_q[0] && style == STYLE_VOLT && active_o
        |-> drive_hi_o && !drive_lo_o) else $error("voltage style drive wrong");
    a_both_style: assert property (ctrl_q[0] && style == STYLE_BOTH
        |-> drive_hi_o == active_o && drive_lo_o == !active_o)
        else $error("combined style drive wrong");
    a_start_active: assert property (cmd_act && beh != BEH_RISE_DLY |=> active_o)
        else $error("activate did not make output active");
    a_stop_inactive: assert property (cmd_deact && beh inside {BEH_MANUAL, BEH_PULSE}
        |=> !active_o) else $error("deactivate did not end output");
    a_rise_waits: assert property (cmd_act && beh == BEH_RISE_DLY && !active_o
        |=> !active_o [*8]) else $error("rise delay went active at once");
    a_manual_steady: assert property (beh == BEH_MANUAL && fs == FS_NONE && !cmd_act
        && !cmd_deact |=> $stable(active_o)) else $error("manual output moved alone");
    a_fs_force_on: assert property (fs == FS_ACTIVE && $rose(failsafe_i)
        |-> ##[3:5] active_o) else $error("failsafe did not activate");
    a_fs_force_off: assert property (fs == FS_INACTIVE && $rose(failsafe_i)
        |-> ##[3:5] !active_o) else $error("failsafe did not deactivate");
endmodule : dout_channel_monitor

bind dout_channel dout_channel_monitor i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .failsafe_i(failsafe_i), .drive_hi_o(drive_hi_o), .drive_lo_o(drive_lo_o),
    .line_oe_o(line_oe_o), .active_o(active_o));

// ===== tb/dout_channel_bench.sv
// Self-checking testbench of the digital output pulse channel.
module dout_channel_bench
    import dout_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Short tick period so timed phases fit the run; phase ends lag the tick by two flops.
    localparam int unsigned TICK_FAST = 20;
    localparam int unsigned LAT       = 2;
    localparam int unsigned LIM       = 200;

    // ========================================================================
    // Stimulus and observation signals.
    logic        clk_i;
    logic        rst_n_i;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic        failsafe_i;
    logic        drive_hi_o;
    logic        drive_lo_o;
    logic        line_oe_o;
    logic        active_o;
    int          num_errors;
    int          checked;
    int          cycles = 0;

    dout_channel #(.TICK_PERIOD(TICK_FAST)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .failsafe_i(failsafe_i), .drive_hi_o(drive_hi_o), .drive_lo_o(drive_lo_o),
        .line_oe_o(line_oe_o), .active_o(active_o));

    // Makes the 100 ns clock.
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ========================================================================
    // Shared tasks.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        check(rdata_o, exp);
    endtask : rd

    // Compares {drive_hi, drive_lo, line_oe, active} under a mask.
    task automatic line(input logic [3:0] exp, input logic [3:0] mask);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({12'h000, {drive_hi_o, drive_lo_o, line_oe_o, active_o} & mask},
            {12'h000, exp & mask});
    endtask : line

    // Counts falling edges while active_o holds the given level, up to a limit.
    task automatic width_of(input logic lvl, input int lim, output int n);
        n = 0;
        while (active_o === lvl && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask : width_of

    // Builds a control word with the line in output direction.
    function automatic logic [15:0] cfg(input style_t s, input beh_t b, input fs_t f);
        return {8'h00, f, 1'b0, b, s, 1'b1};
    endfunction : cfg

    // ========================================================================
    // Scenarios.
    task automatic t_reset();
        rst_n_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        line(4'h0, 4'hF);
    endtask : t_reset

    task automatic t_regs();
        rd(OFS_CTRL, 16'h0000);
        rd(OFS_COUNT, 16'h0001);
        rd(OFS_INACT_W, 16'h0001);
        rd(OFS_ACT_W, 16'h0001);
        rd(OFS_DELAY, 16'h0001);
        rd(4'h7, 16'h0000);
        wr(OFS_INACT_W, 16'h0000);
        rd(OFS_INACT_W, 16'h0001);
        wr(OFS_ACT_W, 16'h2710);
        rd(OFS_ACT_W, 16'h270F);
        wr(OFS_DELAY, 16'h270F);
        rd(OFS_DELAY, 16'h270F);
        wr(OFS_COUNT, 16'h0000);
        rd(OFS_COUNT, 16'h0001);
    endtask : t_regs

    task automatic t_drive();
        style_t     st[3]  = '{STYLE_GND, STYLE_VOLT, STYLE_BOTH};
        logic [3:0] on[3]  = '{4'b0111, 4'b1011, 4'b1011};
        logic [3:0] off[3] = '{4'b0000, 4'b0000, 4'b0110};
        logic [3:0] msk[3] = '{4'b1101, 4'b1101, 4'b1111};
        wr(OFS_CMD, 16'h0001);
        line(4'b0001, 4'hF);
        wr(OFS_CMD, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, cfg(st[i], BEH_MANUAL, FS_NONE));
            wr(OFS_CMD, 16'h0001);
            line(on[i], 4'hF);
            wr(OFS_CMD, 16'h0002);
            line(off[i], msk[i]);
        end
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_MANUAL, FS_NONE));
        wr(OFS_CMD, 16'h0001);
        repeat (50) @(posedge clk_i);
        line(4'b0111, 4'hF);
        wr(OFS_CMD, 16'h0002);
    endtask : t_drive

    task automatic t_pulse();
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CTRL, cfg(STYLE_GND, BEH_PULSE, FS_NONE) | (c ? 16'h0020 : 16'h0000));
            wr(OFS_CMD, 16'h0001);
            line(4'b0111, 4'hF);
            wr(OFS_CMD, 16'h0002);
            line(4'b0000, 4'b1101);
        end
    endtask : t_pulse

    task automatic t_delay();
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_RISE_DLY, FS_NONE));
        wr(OFS_CMD, 16'h0001);
        repeat (20) @(posedge clk_i);
        line(4'b0000, 4'b1101);
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_FALL_DLY, FS_NONE));
        wr(OFS_CMD, 16'h0001);
        line(4'b0111, 4'hF);
        wr(OFS_CMD, 16'h0002);
        line(4'b0111, 4'hF);
        t_reset();
    endtask : t_delay

    task automatic t_failsafe();
        fs_t         fa[3]  = '{FS_ACTIVE, FS_INACTIVE, FS_NONE};
        logic [15:0] pre[3] = '{16'h0002, 16'h0001, 16'h0001};
        logic [3:0]  ex[3]  = '{4'b0001, 4'b0000, 4'b0001};
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, cfg(STYLE_GND, BEH_MANUAL, fa[i]));
            wr(OFS_CMD, pre[i]);
            @(posedge clk_i);
            failsafe_i <= 1'b1;
            repeat (8) @(posedge clk_i);
            failsafe_i <= 1'b0;
            line(ex[i], 4'b0001);
        end
    endtask : t_failsafe

    // Measures timed phases: counted and continuous pulses, both delays.
    task automatic t_timing();
        int n;
        wr(OFS_ACT_W, 16'h0002);
        wr(OFS_COUNT, 16'h0002);
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_PULSE, FS_NONE) | 16'h0020);
        wr(OFS_CMD, 16'h0001);
        @(negedge clk_i);
        for (int k = 0; k < 2; k++) begin
            width_of(1'b1, LIM, n);
            check(16'(n), 16'(2 * TICK_FAST + LAT));
            width_of(1'b0, LIM, n);
            check(16'(n), k ? 16'(LIM) : 16'(TICK_FAST + LAT));
        end
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_PULSE, FS_NONE));
        wr(OFS_CMD, 16'h0001);
        @(negedge clk_i);
        for (int k = 0; k < 3; k++) begin
            width_of(1'b1, LIM, n);
            check(16'(n), 16'(2 * TICK_FAST + LAT));
            width_of(1'b0, LIM, n);
            check(16'(n), 16'(TICK_FAST + LAT));
        end
        wr(OFS_CMD, 16'h0002);
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_RISE_DLY, FS_NONE));
        wr(OFS_CMD, 16'h0001);
        @(negedge clk_i);
        width_of(1'b0, LIM, n);
        check(16'(n), 16'(TICK_FAST + LAT));
        wr(OFS_CTRL, cfg(STYLE_GND, BEH_FALL_DLY, FS_NONE));
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CMD, 16'h0001);
            if (k) begin
                wr(OFS_CMD, 16'h0002);
            end
            @(negedge clk_i);
            width_of(1'b1, LIM, n);
            check(16'(n), 16'(TICK_FAST + LAT));
        end
    endtask : t_timing

    // Cuts a hung run short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    // Main sequence.
    initial begin
        rst_n_i    = 1'b0;
        addr_i     = 4'h0;
        wdata_i    = 16'h0000;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        failsafe_i = 1'b0;
        num_errors = 0;
        checked    = 0;
        t_reset();
        t_regs();
        t_drive();
        t_pulse();
        t_delay();
        t_failsafe();
        t_timing();
        stop_test();
    end
endmodule : dout_channel_bench
